// file: hw/pin_config_and_gpio_regs.sv
// pin function, overtemp policy, attenuator bypass and io line registers
`timescale 1ns/1ps
`default_nettype none
module pin_config_and_gpio_regs
  import pin_cfg_pkg::*;
(
  input  wire logic        clock,          // 25 MHz system clock
  input  wire logic        sys_rst,        // sync reset, active high
  input  wire logic [7:0]  reg_addr,       // register pointer
  input  wire logic [7:0]  reg_wdata,      // write data
  input  wire logic        reg_wr,         // write strobe
  input  wire logic        reg_rd,         // read strobe
  output logic      [7:0]  reg_rdata,      // read data, held
  input  wire logic        reg_lock,       // pin config register write lock, io line config writes not locked
  input  wire logic        temperature_format_select, // 1 temperature_format_select
  input  wire logic [3:0]  chan_over,      // channel over its limit
  input  wire logic [31:0] chan_limit,     // limits, channel 0 low
  input  wire logic        alert_req,      // alert request, high
  input  wire logic [23:0] fan_max_speed,  // fan maximum, fan 0 low
  input  wire logic        shared_pin_in,  // shared pin level
  output logic             shared_pin_out, // shared pin drive level
  output logic             shared_pin_oe_n,// low while driving
  output logic             fan_tach_input_four, // tach from pin
  output logic             overtemp_active,// overtemp in force
  output logic             fan_force_en,   // override fan duty
  output logic      [23:0] fan_force_duty, // forced duty per fan
  output logic      [3:0]  attenuator_bypass, // bypass per channel
  input  wire logic        io_line_one_in, // line one pin level
  output logic             io_line_one_out,// line one drive
  output logic             io_line_one_oe_n, // line one enable
  input  wire logic        io_line_two_in, // line two pin level
  output logic             io_line_two_out,// line two drive
  output logic             io_line_two_oe_n  // line two enable
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]  pin_cfg;
    logic [7:0]  io_cfg;
    logic [7:0]  rdata;
    logic        ot;
    logic        tach;
    logic        pout;
    logic        poe_n;
    logic        force_en;
    logic [23:0] duty;
  } regs_s;
  regs_s st_q, st_d;

  logic       one_rd;
  logic       two_rd;
  logic [3:0] chan_live;
  logic [7:0] io_view;

  // a limit at the floor code means the channel is switched off
  function automatic logic chan_off(input logic [7:0] lim,
                                    input logic       twos);
    chan_off = twos ? (lim == LIMIT_OFF_TWOS)
                    : (lim == LIMIT_OFF_OFFSET64);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // per channel enable after the floor check
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      chan_live[i] = chan_over[i] &&
        !chan_off(chan_limit[i*8 +: 8], temperature_format_select);
    end
  end

  // io config as read: reserved low bits zero, data bits per line
  always_comb begin
    io_view               = st_q.io_cfg & IO_WRITE_MASK;
    io_view[FLD_ONE_DATA] = one_rd;
    io_view[FLD_TWO_DATA] = two_rd;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    // pin config frozen while the lock input is high
    if (reg_wr && hit(reg_addr, ADDR_PIN_OT_CFG) && !reg_lock) begin
      st_d.pin_cfg = reg_wdata;
    end
    // reserved bits never stored
    if (reg_wr && hit(reg_addr, ADDR_IO_LINE_CFG)) begin
      st_d.io_cfg = reg_wdata & IO_WRITE_MASK;
    end
    // test registers take no writes and read zero
    if (reg_rd) begin
      if (hit(reg_addr, ADDR_PIN_OT_CFG)) begin
        st_d.rdata = st_q.pin_cfg;
      end else if (hit(reg_addr, ADDR_IO_LINE_CFG)) begin
        st_d.rdata = io_view;
      end else begin
        st_d.rdata = RST_MFR_TEST;
      end
    end
    // overtemp summary, global disable wins
    st_d.ot = |chan_live && !st_q.pin_cfg[FLD_OT_DISABLE];
    // fan override follows overtemp and policy
    st_d.force_en = st_q.ot;
    for (int f = 0; f < NUM_FANS; f++) begin
      st_d.duty[f*8 +: 8] = st_q.pin_cfg[FLD_OT_POLICY]
                          ? fan_max_speed[f*8 +: 8]
                          : DUTY_FULL;
    end
    // shared pin routing, open drain active low when driving
    st_d.tach  = 1'b0;
    st_d.pout  = 1'b0;
    st_d.poe_n = 1'b1;
    case (st_q.pin_cfg[FLD_FUNC_LO +: 2])
      FUNC_TACH: begin
        st_d.tach = shared_pin_in;
      end
      FUNC_OVERTEMP: begin
        st_d.poe_n = !st_q.ot;
      end
      FUNC_ALERT: begin
        st_d.poe_n = !alert_req;
      end
      default: begin
        st_d.poe_n = 1'b1;
      end
    endcase
    if (sys_rst) begin
      st_d = '{pin_cfg: RST_PIN_OT_CFG, io_cfg: RST_IO_LINE_CFG,
               rdata: RST_MFR_TEST, ot: 1'b0, tach: 1'b0,
               pout: 1'b0, poe_n: 1'b1, force_en: 1'b0,
               duty: '0};
    end
  end

  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  // ****************************************
  // io lines
  // ****************************************
  io_line u_line_one (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .data_bit (st_q.io_cfg[FLD_ONE_DATA]),
    .pol_bit  (st_q.io_cfg[FLD_ONE_POL]),
    .dir_bit  (st_q.io_cfg[FLD_ONE_DIR]),
    .pin_in   (io_line_one_in),
    .pin_out  (io_line_one_out),
    .pin_oe_n (io_line_one_oe_n),
    .read_bit (one_rd)
  );
  io_line u_line_two (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .data_bit (st_q.io_cfg[FLD_TWO_DATA]),
    .pol_bit  (st_q.io_cfg[FLD_TWO_POL]),
    .dir_bit  (st_q.io_cfg[FLD_TWO_DIR]),
    .pin_in   (io_line_two_in),
    .pin_out  (io_line_two_out),
    .pin_oe_n (io_line_two_oe_n),
    .read_bit (two_rd)
  );

  // outputs straight from the state register
  assign reg_rdata           = st_q.rdata;
  assign shared_pin_out      = st_q.pout;
  assign shared_pin_oe_n     = st_q.poe_n;
  assign fan_tach_input_four = st_q.tach;
  assign overtemp_active     = st_q.ot;
  assign fan_force_en        = st_q.force_en;
  assign fan_force_duty      = st_q.duty;
  assign attenuator_bypass   = st_q.pin_cfg[FLD_BYPASS_LO +: 4];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_locked_write;
    reg_wr && reg_lock && reg_addr == ADDR_PIN_OT_CFG;
  endsequence
  sequence s_read_pin_cfg;
    reg_rd && reg_addr == ADDR_PIN_OT_CFG;
  endsequence

  a_lock_holds_cfg: assert property (
    s_locked_write |=> $stable(st_q.pin_cfg))
    else $error("locked pin config changed");
  a_pin_cfg_read: assert property (
    s_read_pin_cfg |=> reg_rdata == $past(st_q.pin_cfg))
    else $error("pin config read back wrong");
  a_test_reads_zero: assert property (
    reg_rd && (reg_addr == ADDR_MFR_TEST_ONE ||
               reg_addr == ADDR_MFR_TEST_TWO)
    |=> reg_rdata == RST_MFR_TEST)
    else $error("test register not zero");
  a_io_rsvd_zero: assert property (
    reg_rd && reg_addr == ADDR_IO_LINE_CFG |=> reg_rdata[1:0] == 2'h0)
    else $error("io reserved bits not zero");
  a_ot_disable_all: assert property (
    st_q.pin_cfg[FLD_OT_DISABLE] ##1 st_q.pin_cfg[FLD_OT_DISABLE]
    |-> !overtemp_active)
    else $error("overtemp not suppressed");
  a_chan_floor_off: assert property (
    chan_over == 4'h1 && !st_q.pin_cfg[FLD_OT_DISABLE] &&
    chan_limit[7:0] == (temperature_format_select ? LIMIT_OFF_TWOS
                                                  : LIMIT_OFF_OFFSET64)
    |=> !overtemp_active)
    else $error("floor limit did not switch channel off");
  a_fan_full_duty: assert property (
    overtemp_active && !st_q.pin_cfg[FLD_OT_POLICY] &&
    $stable(st_q.pin_cfg)
    |=> fan_force_en && fan_force_duty == {3{DUTY_FULL}})
    else $error("fans not at full duty");
  a_fan_max_duty: assert property (
    overtemp_active && st_q.pin_cfg[FLD_OT_POLICY] && $stable(st_q.pin_cfg)
    |=> fan_force_en && fan_force_duty == $past(fan_max_speed))
    else $error("fans not at maximum");
  a_pin_tach_mode: assert property (
    st_q.pin_cfg[1:0] == FUNC_TACH
    |=> shared_pin_oe_n && fan_tach_input_four == $past(shared_pin_in))
    else $error("tach mode pin wrong");
  a_pin_alert_mode: assert property (
    st_q.pin_cfg[1:0] == FUNC_ALERT && alert_req
    |=> !shared_pin_oe_n && !shared_pin_out)
    else $error("alert not driven");
endmodule
`default_nettype wire

// file: hw/pin_cfg_pkg.sv
// constants for the pin configuration and io line register group
package pin_cfg_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_MFR_TEST_ONE = 8'h7e;
  localparam logic [7:0] ADDR_MFR_TEST_TWO = 8'h7f;
  localparam logic [7:0] ADDR_IO_LINE_CFG  = 8'h80;
  localparam logic [7:0] ADDR_PIN_OT_CFG   = 8'h7d;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_PIN_OT_CFG  = 8'h00;
  localparam logic [7:0] RST_IO_LINE_CFG = 8'h00;
  localparam logic [7:0] RST_MFR_TEST    = 8'h00;
  // ****************************************
  // pin and overtemp config fields
  // ****************************************
  localparam int FLD_FUNC_LO    = 0;
  localparam int FLD_OT_DISABLE = 2;
  localparam int FLD_OT_POLICY  = 3;
  localparam int FLD_BYPASS_LO  = 4;
  // ****************************************
  // io line config fields
  // ****************************************
  localparam int FLD_TWO_DATA = 2;
  localparam int FLD_ONE_DATA = 3;
  localparam int FLD_TWO_POL  = 4;
  localparam int FLD_ONE_POL  = 5;
  localparam int FLD_TWO_DIR  = 6;
  localparam int FLD_ONE_DIR  = 7;
  localparam logic [7:0] IO_WRITE_MASK = 8'hfc;
  // ****************************************
  // shared pin function codes
  // ****************************************
  localparam logic [1:0] FUNC_TACH     = 2'h0;
  localparam logic [1:0] FUNC_OVERTEMP = 2'h1;
  localparam logic [1:0] FUNC_ALERT    = 2'h2;
  // ****************************************
  // limit codes that switch a channel off, full fan duty, channel and fan counts
  // ****************************************
  localparam logic [7:0] LIMIT_OFF_OFFSET64 = 8'h00; // -64 degrees
  localparam logic [7:0] LIMIT_OFF_TWOS     = 8'h80; // -128 degrees
  localparam logic [7:0] DUTY_FULL          = 8'hff;
  localparam int NUM_CHAN = 4;
  localparam int NUM_FANS = 3;
endpackage

// file: hw/io_line.sv
// one general purpose io line: pin drive and level capture
`timescale 1ns/1ps
`default_nettype none
module io_line
  import pin_cfg_pkg::*;
(
  input  wire logic clock,    // system clock
  input  wire logic sys_rst,  // sync reset, active high
  input  wire logic data_bit, // stored data bit
  input  wire logic pol_bit,  // 1 active high, 0 active low
  input  wire logic dir_bit,  // 1 input, 0 output
  input  wire logic pin_in,   // pin level
  output logic      pin_out,  // pin drive level
  output logic      pin_oe_n, // low while driving
  output logic      read_bit  // value seen in the data bit
);
  typedef struct packed {
    logic out;
    logic oe_n;
    logic lvl;
  } line_s;
  line_s st_q, st_d;

  // drive level follows polarity, pin level captured every cycle
  always_comb begin
    st_d      = st_q;
    st_d.out  = pol_bit ? data_bit : ~data_bit;
    st_d.oe_n = dir_bit;
    st_d.lvl  = pin_in;
    if (sys_rst) begin
      st_d = '{out: 1'b0, oe_n: 1'b1, lvl: 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  assign pin_out  = st_q.out;
  assign pin_oe_n = st_q.oe_n;
  // input lines report the pin, output lines the stored bit
  assign read_bit = dir_bit ? st_q.lvl : data_bit;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_line_drive: assert property (
    !dir_bit && $stable(dir_bit) && $stable(data_bit) && $stable(pol_bit)
    |=> !pin_oe_n && (pin_out == ($past(pol_bit) ~^ $past(data_bit))))
    else $error("io line drive level wrong");
  a_line_input: assert property (
    dir_bit ##1 dir_bit |-> pin_oe_n && read_bit == $past(pin_in))
    else $error("io line input not reported");
endmodule
`default_nettype wire

// file: tb/smbus_host_model.sv
// host model driving the register port of the pin config block
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
  import pin_cfg_pkg::*;
(
  input  wire logic       clock,     // system clock
  output logic      [7:0] reg_addr,  // register pointer
  output logic      [7:0] reg_wdata, // write data
  output logic            reg_wr,    // write strobe
  output logic            reg_rd,    // read strobe
  input  wire logic [7:0] reg_rdata  // read data
);
  // idle strobes low, pointer and data parked
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one strobe cycle; idle bus shows inverted value so stale data fails
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_MFR_TEST_ONE || a == ADDR_MFR_TEST_TWO) begin
      return;
    end
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // read data registered on the strobe edge, taken half a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: tb/pin_config_and_gpio_regs_tb_top.sv
// self-checking bench for the pin config and io line registers
`timescale 1ns/1ps
`default_nettype none
module pin_config_and_gpio_regs_tb_top;
  import pin_cfg_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd;
  logic        reg_lock = 1'b0, fmt = 1'b0, alert_req = 1'b0;
  logic [3:0]  chan_over = 4'h0, bypass;
  logic [31:0] chan_limit = 32'h10101010;
  logic [23:0] fan_max = 24'h302010, duty;
  logic        ext_pin = 1'b1, one_lvl = 1'b1, two_lvl = 1'b0;
  logic        sp_out, sp_oe_n, tach, ot_act, force_en;
  logic        one_out, one_oe_n, two_out, two_oe_n;
  // pin levels: pulled up shared pin, io lines driven by bench when free
  wire         sp_wire  = sp_oe_n ? ext_pin : sp_out;
  wire         one_wire = one_oe_n ? one_lvl : one_out;
  wire         two_wire = two_oe_n ? two_lvl : two_out;
  int          mismatches = 0;
  int          check_count = 0;
  // 25 MHz clock
  always #20 clock = ~clock;
  smbus_host_model u_smbus_host_model (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  pin_config_and_gpio_regs u_pin_config_and_gpio_regs (.clock(clock),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_lock(reg_lock), .temperature_format_select(fmt),
    .chan_over(chan_over), .chan_limit(chan_limit), .alert_req(alert_req),
    .fan_max_speed(fan_max), .shared_pin_in(sp_wire),
    .shared_pin_out(sp_out), .shared_pin_oe_n(sp_oe_n),
    .fan_tach_input_four(tach), .overtemp_active(ot_act),
    .fan_force_en(force_en), .fan_force_duty(duty),
    .attenuator_bypass(bypass), .io_line_one_in(one_wire),
    .io_line_one_out(one_out), .io_line_one_oe_n(one_oe_n),
    .io_line_two_in(two_wire), .io_line_two_out(two_out),
    .io_line_two_oe_n(two_oe_n));
  // ****************************************
  // compare and report helpers
  // ****************************************
  task automatic chk(input string n, input logic [23:0] s, e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(input string n, input logic s, e);
    chk(n, {23'h0, s}, {23'h0, e});
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_smbus_host_model.rd(a, d);
    chk("reg_rdata", {16'h0, d}, {16'h0, e});
  endtask
  task automatic settle();
    repeat (3) @(negedge clock);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk_reg(ADDR_PIN_OT_CFG, RST_PIN_OT_CFG);
    chk_reg(ADDR_MFR_TEST_ONE, RST_MFR_TEST);
    chk_reg(ADDR_MFR_TEST_TWO, RST_MFR_TEST);
    chk_reg(ADDR_IO_LINE_CFG, RST_IO_LINE_CFG);
    chk_reg(8'h55, 8'h00);
    chk1("io_line_one_oe_n", one_oe_n, 1'b0);
    chk1("io_line_two_out", two_out, 1'b1);
  endtask
  // every pin function code, tach, overtemp and alert each with its own source active
  task automatic t_func();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      u_smbus_host_model.wr(ADDR_PIN_OT_CFG, {6'h0, c});
      alert_req = (c == FUNC_ALERT);
      chan_over = (c == FUNC_OVERTEMP) ? 4'h1 : 4'h0;
      settle();
      chk1("fan_tach_input_four", tach, c == FUNC_TACH);
      chk1("shared_pin_oe_n", sp_oe_n, c[0] == c[1]);
      chk1("shared_pin_out", sp_out, 1'b0);
    end
    alert_req = 1'b0;
  endtask
  // fan policy, global disable and per channel floor limits
  task automatic t_overtemp();
    u_smbus_host_model.wr(ADDR_PIN_OT_CFG, 8'h01);
    chan_over = 4'h1;
    settle();
    chk1("fan_force_en", force_en, 1'b1);
    chk("fan_force_duty", duty, {3{DUTY_FULL}});
    u_smbus_host_model.wr(ADDR_PIN_OT_CFG, 8'h09);
    settle();
    chk("fan_force_duty", duty, fan_max);
    u_smbus_host_model.wr(ADDR_PIN_OT_CFG, 8'h05);
    settle();
    chk1("overtemp_active", ot_act, 1'b0);
    chk1("shared_pin_oe_n", sp_oe_n, 1'b1);
    u_smbus_host_model.wr(ADDR_PIN_OT_CFG, 8'h01);
    chan_limit[7:0] = LIMIT_OFF_TWOS;
    settle();
    chk1("overtemp_active", ot_act, 1'b1);
    fmt = 1'b1;
    settle();
    chk1("overtemp_active", ot_act, 1'b0);
    chan_limit[7:0] = LIMIT_OFF_OFFSET64;
    settle();
    chk1("overtemp_active", ot_act, 1'b1);
    fmt = 1'b0;
    settle();
    chk1("overtemp_active", ot_act, 1'b0);
    chan_over = 4'h3;
    settle();
    chk1("overtemp_active", ot_act, 1'b1);
    chan_over = 4'h0;
    chan_limit = 32'h10101010;
  endtask
  // bypass bits, then a locked write that must change nothing
  task automatic t_bypass_lock();
    u_smbus_host_model.wr(ADDR_PIN_OT_CFG, 8'hf0);
    settle();
    chk("attenuator_bypass", {20'h0, bypass}, 24'hf);
    u_smbus_host_model.wr(ADDR_PIN_OT_CFG, 8'h50);
    reg_lock = 1'b1;
    u_smbus_host_model.wr(ADDR_PIN_OT_CFG, 8'ha2);
    settle();
    chk("attenuator_bypass", {20'h0, bypass}, 24'h5);
    chk_reg(ADDR_PIN_OT_CFG, 8'h50);
    reg_lock = 1'b0;
    u_smbus_host_model.wr(ADDR_PIN_OT_CFG, 8'h00);
    chk_reg(ADDR_PIN_OT_CFG, 8'h00);
  endtask
  // io lines as outputs of both polarities, then as inputs
  task automatic t_io();
    u_smbus_host_model.wr(ADDR_IO_LINE_CFG, 8'h3c);
    chk_reg(ADDR_IO_LINE_CFG, 8'h3c);
    chk1("io_line_one_out", one_out, 1'b1);
    chk1("io_line_two_oe_n", two_oe_n, 1'b0);
    u_smbus_host_model.wr(ADDR_IO_LINE_CFG, 8'h2c);
    settle();
    chk1("io_line_one_out", one_out, 1'b1);
    chk1("io_line_two_out", two_out, 1'b0);
    u_smbus_host_model.wr(ADDR_IO_LINE_CFG, 8'hc3);
    settle();
    chk1("io_line_one_oe_n", one_oe_n, 1'b1);
    chk_reg(ADDR_IO_LINE_CFG, 8'hc8);
    one_lvl = 1'b0;
    two_lvl = 1'b1;
    settle();
    chk_reg(ADDR_IO_LINE_CFG, 8'hc4);
  endtask
  // reset in mid run brings every register back to its default
  task automatic t_mid_reset();
    u_smbus_host_model.wr(ADDR_PIN_OT_CFG, 8'hf6);
    u_smbus_host_model.wr(ADDR_IO_LINE_CFG, 8'hfc);
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    chk("attenuator_bypass", {20'h0, bypass}, 24'h0);
    chk_reg(ADDR_PIN_OT_CFG, RST_PIN_OT_CFG);
    chk_reg(ADDR_IO_LINE_CFG, RST_IO_LINE_CFG);
    chk1("io_line_one_oe_n", one_oe_n, 1'b0);
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    t_reset();
    t_func();
    t_overtemp();
    t_bypass_lock();
    t_io();
    t_mid_reset();
    end_sim();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
